// File: ccc_pkg.sv
// package for the backup cell charger control block
// assumes a single clock domain; power state arrives as a coded input
package ccc_pkg;

   // ************************************************************
   // power states
   // ************************************************************
   typedef enum logic [1:0] {
      CCC_PWR_RUN      = 2'b00,
      CCC_PWR_STANDBY  = 2'b01,
      CCC_PWR_DEEP_OFF = 2'b10,
      CCC_PWR_OTHER    = 2'b11
   } ccc_pwr_e;

   // ************************************************************
   // widths, reset values and current levels
   // ************************************************************
   localparam int   CCC_VCODE_W       = 4;
   localparam logic CCC_EN_RST        = 1'b0;
   localparam logic CCC_CUR_LOW       = 1'b0;  // 10 uA
   localparam logic CCC_CUR_HIGH      = 1'b1;  // 60 uA
   localparam int   CCC_CUR_LOW_UA    = 10;
   localparam int   CCC_CUR_HIGH_UA   = 60;

   // target level in tens of millivolts per code
   localparam int   CCC_LVL_W         = 9;
   localparam logic [CCC_LVL_W-1:0] CCC_LVL_CODE0    = 9'h0B4;  // 1.80 V
   localparam logic [CCC_LVL_W-1:0] CCC_LVL_CODE1    = 9'h0C8;  // 2.00 V
   localparam logic [CCC_LVL_W-1:0] CCC_LVL_BASE     = 9'h0C8;  // 2.0 V + (n-1) * 0.1 V, 1<=n<=14
   localparam logic [CCC_LVL_W-1:0] CCC_LVL_STEP     = 9'h00A;  // 0.1 V
   localparam logic [CCC_LVL_W-1:0] CCC_LVL_CODE15   = 9'h168;  // 3.60 V
   localparam logic [CCC_VCODE_W-1:0] CCC_CODE_MIN   = 4'h0;
   localparam logic [CCC_VCODE_W-1:0] CCC_CODE_ONE   = 4'h1;
   localparam logic [CCC_VCODE_W-1:0] CCC_CODE_MAX   = 4'hF;

endpackage

// File: ccc_charger_ctrl.sv
// control logic of the backup cell constant-current charger
// assumes register writes arrive as one-cycle strobes from the serial
// interface, power state and stay-in-off option come from the state machine,
// undervoltage comparator output is asynchronous to mclk_i
`timescale 1ns/1ns

module ccc_charger_ctrl (
   input  wire logic                            mclk_i,
   input  wire logic                            reset_i,
   input  wire logic                            uv_above_threshold_i,
   input  wire logic [1:0]                      power_state_i,
   input  wire logic                            stay_in_deep_off_i,
   input  wire logic                            on_enable_wr_i,
   input  wire logic                            on_enable_wdata_i,
   input  wire logic                            off_enable_wr_i,
   input  wire logic                            off_enable_wdata_i,
   input  wire logic                            vcode_wr_i,
   input  wire logic [ccc_pkg::CCC_VCODE_W-1:0] vcode_wdata_i,
   input  wire logic                            fuse_load_i,
   input  wire logic [ccc_pkg::CCC_VCODE_W-1:0] fuse_backup_target_voltage_code_i,
   output logic                                 backup_charge_on_enable_o,
   output logic                                 backup_charge_deep_off_enable_o,
   output logic [ccc_pkg::CCC_VCODE_W-1:0]      backup_target_voltage_code_o,
   output logic                                 charger_enable_o,
   output logic                                 charger_current_high_o,
   output logic [ccc_pkg::CCC_LVL_W-1:0]        charger_target_level_o
);

   // ************************************************************
   // undervoltage comparator synchroniser and rising edge
   // ************************************************************
   logic                             uv_s1_ff;
   logic                             uv_s2_ff;
   logic                             uv_s3_ff;
   logic                             uv_state_ff;
   logic                             uv_rise;

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         uv_s1_ff <= 1'b0;
         uv_s2_ff <= 1'b0;
         uv_s3_ff <= 1'b0;
      end else begin
         uv_s1_ff <= uv_above_threshold_i;
         uv_s2_ff <= uv_s1_ff;
         uv_s3_ff <= uv_s2_ff;
      end
   end

   // a change counts once the second and third stages agree
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         uv_state_ff <= 1'b0;
      end else if (uv_s2_ff == uv_s3_ff) begin
         uv_state_ff <= uv_s3_ff;
      end
   end

   assign uv_rise = (uv_s2_ff == uv_s3_ff) && uv_s3_ff && !uv_state_ff;

   // ************************************************************
   // enable bits
   // ************************************************************
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         backup_charge_on_enable_o <= ccc_pkg::CCC_EN_RST;
      end else if (uv_rise) begin
         backup_charge_on_enable_o <= ccc_pkg::CCC_EN_RST;
      end else if (on_enable_wr_i) begin
         backup_charge_on_enable_o <= on_enable_wdata_i;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         backup_charge_deep_off_enable_o <= ccc_pkg::CCC_EN_RST;
      end else if (uv_rise) begin
         backup_charge_deep_off_enable_o <= ccc_pkg::CCC_EN_RST;
      end else if (off_enable_wr_i) begin
         backup_charge_deep_off_enable_o <= off_enable_wdata_i;
      end
   end

   // ************************************************************
   // target voltage code
   // ************************************************************
   // the fuse value is reloaded on each supply rise as well
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         backup_target_voltage_code_o <= ccc_pkg::CCC_CODE_MIN;
      end else if (fuse_load_i || uv_rise) begin
         backup_target_voltage_code_o <= fuse_backup_target_voltage_code_i;
      end else if (vcode_wr_i) begin
         backup_target_voltage_code_o <= vcode_wdata_i;
      end
   end

   localparam int CCC_LVL_W = ccc_pkg::CCC_LVL_W;

   logic [ccc_pkg::CCC_LVL_W-1:0] nxt_level;

   always_comb begin
      if (backup_target_voltage_code_o == ccc_pkg::CCC_CODE_MIN) begin
         nxt_level = ccc_pkg::CCC_LVL_CODE0;
      end else if (backup_target_voltage_code_o == ccc_pkg::CCC_CODE_MAX) begin
         nxt_level = ccc_pkg::CCC_LVL_CODE15;
      end else begin
         nxt_level = ccc_pkg::CCC_LVL_BASE + CCC_LVL_W'(ccc_pkg::CCC_LVL_STEP
                     * CCC_LVL_W'(backup_target_voltage_code_o - ccc_pkg::CCC_CODE_ONE));
      end
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         charger_target_level_o <= ccc_pkg::CCC_LVL_CODE0;
      end else begin
         charger_target_level_o <= nxt_level;
      end
   end

   // ************************************************************
   // charger enable and current select
   // ************************************************************
   logic nxt_enable;
   logic nxt_cur_high;

   always_comb begin
      nxt_enable   = 1'b0;
      nxt_cur_high = ccc_pkg::CCC_CUR_LOW;
      case (ccc_pkg::ccc_pwr_e'(power_state_i))
         ccc_pkg::CCC_PWR_RUN: begin
            nxt_enable   = backup_charge_on_enable_o;
            nxt_cur_high = ccc_pkg::CCC_CUR_HIGH;
         end
         ccc_pkg::CCC_PWR_STANDBY: begin
            nxt_enable   = backup_charge_on_enable_o;
            nxt_cur_high = ccc_pkg::CCC_CUR_LOW;
         end
         ccc_pkg::CCC_PWR_DEEP_OFF: begin
            nxt_enable   = backup_charge_deep_off_enable_o && stay_in_deep_off_i;
            nxt_cur_high = ccc_pkg::CCC_CUR_LOW;
         end
         default: begin
            nxt_enable   = 1'b0;
            nxt_cur_high = ccc_pkg::CCC_CUR_LOW;
         end
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         charger_enable_o       <= 1'b0;
         charger_current_high_o <= ccc_pkg::CCC_CUR_LOW;
      end else begin
         charger_enable_o       <= nxt_enable;
         charger_current_high_o <= nxt_cur_high;
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   chk_run_enable: assert property (@(posedge mclk_i) disable iff (reset_i)
      !$past(reset_i) && ($past(power_state_i) == 2'b00 || $past(power_state_i) == 2'b01) |->
      charger_enable_o == $past(backup_charge_on_enable_o))
      else $error("charger enable does not follow on-enable in run or standby");

   chk_uv_clear: assert property (@(posedge mclk_i) disable iff (reset_i)
      uv_rise |=> !backup_charge_on_enable_o && !backup_charge_deep_off_enable_o)
      else $error("enables not cleared on supply rise");

   chk_uv_sync: assert property (@(posedge mclk_i) disable iff (reset_i)
      uv_rise |-> $past(uv_above_threshold_i, 2) && $past(uv_above_threshold_i, 3) && !$past(uv_rise))
      else $error("supply rise not confirmed by two samples");

   chk_run_current: assert property (@(posedge mclk_i) disable iff (reset_i)
      !$past(reset_i) && $past(power_state_i) == 2'b00 |-> charger_current_high_o)
      else $error("run mode not at high current");

   chk_stby_current: assert property (@(posedge mclk_i) disable iff (reset_i)
      $past(power_state_i) == 2'b01 |-> !charger_current_high_o)
      else $error("standby not at low current");

   chk_off_enable: assert property (@(posedge mclk_i) disable iff (reset_i)
      $past(power_state_i) == 2'b10 |->
      charger_enable_o == ($past(backup_charge_deep_off_enable_o) && $past(stay_in_deep_off_i))
      && !charger_current_high_o)
      else $error("deep-off charging wrong");

   chk_off_stay: assert property (@(posedge mclk_i) disable iff (reset_i)
      $past(power_state_i) == 2'b10 && !$past(stay_in_deep_off_i) |-> !charger_enable_o)
      else $error("deep-off charging without stay option");

   chk_level_ends: assert property (@(posedge mclk_i) disable iff (reset_i)
      ($past(backup_target_voltage_code_o) == 4'hF |-> charger_target_level_o == 9'h168) and
      ($past(backup_target_voltage_code_o) == 4'h0 |-> charger_target_level_o == 9'h0B4) and
      ($past(backup_target_voltage_code_o) == 4'h2 |-> charger_target_level_o == 9'h0D2))
      else $error("target level decode wrong");

   chk_fuse_load: assert property (@(posedge mclk_i) disable iff (reset_i)
      fuse_load_i |=> backup_target_voltage_code_o == $past(fuse_backup_target_voltage_code_i))
      else $error("fuse code not loaded");

   chk_other_off: assert property (@(posedge mclk_i) disable iff (reset_i)
      $past(power_state_i) == 2'b11 |-> !charger_enable_o)
      else $error("charger enabled in other state");

   cov_run_charge:  cover property (@(posedge mclk_i) charger_enable_o && charger_current_high_o);
   cov_stby_charge: cover property (@(posedge mclk_i) charger_enable_o && !charger_current_high_o);
   cov_uv_clear:    cover property (@(posedge mclk_i) uv_rise && backup_charge_on_enable_o);

endmodule

// File: coin_cell_charger_control_bench.sv
// self-checking bench for the backup cell charger control block
// assumes the checks of the design sit in its own files; ports driven 1 ns after mclk_i rises
`timescale 1ns/1ns
module coin_cell_charger_control_bench;
   // ************************************************************
   // stimulus and observed signals
   // ************************************************************
   logic       mclk_i = 1'b0;
   logic       reset_i = 1'b1;
   logic       uv_above_threshold_i = 1'b0;
   logic [1:0] power_state_i = 2'b00;
   logic       stay_in_deep_off_i = 1'b0;
   logic       on_enable_wr_i = 1'b0;
   logic       on_enable_wdata_i = 1'b0;
   logic       off_enable_wr_i = 1'b0;
   logic       off_enable_wdata_i = 1'b0;
   logic       vcode_wr_i = 1'b0;
   logic [3:0] vcode_wdata_i = 4'h0;
   logic       fuse_load_i = 1'b0;
   logic [3:0] fuse_code = 4'h0;
   logic       on_q, off_q, chg_en, chg_hi;
   logic [3:0] code_q;
   logic [8:0] lvl_q;
   int         bad_count = 0;
   int         num_checks = 0;
   int         cyc = 0;
   ccc_charger_ctrl i_ccc_charger_ctrl (.mclk_i(mclk_i), .reset_i(reset_i),
      .uv_above_threshold_i(uv_above_threshold_i), .power_state_i(power_state_i),
      .stay_in_deep_off_i(stay_in_deep_off_i), .on_enable_wr_i(on_enable_wr_i),
      .on_enable_wdata_i(on_enable_wdata_i), .off_enable_wr_i(off_enable_wr_i),
      .off_enable_wdata_i(off_enable_wdata_i), .vcode_wr_i(vcode_wr_i), .vcode_wdata_i(vcode_wdata_i),
      .fuse_load_i(fuse_load_i), .fuse_backup_target_voltage_code_i(fuse_code),
      .backup_charge_on_enable_o(on_q), .backup_charge_deep_off_enable_o(off_q),
      .backup_target_voltage_code_o(code_q), .charger_enable_o(chg_en),
      .charger_current_high_o(chg_hi), .charger_target_level_o(lvl_q));
   always #5 mclk_i = ~mclk_i;
   // ************************************************************
   // tasks
   // ************************************************************
   task automatic finish_test;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
      num_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %0t %s seen %h expected %h", $time, msg, seen, exp);
      end
   endtask
   task automatic tick;
      @(posedge mclk_i);
      #1;
   endtask
   // k: 0 on-enable, 1 deep-off enable, 2 voltage code, 3 fuse load; ends with charger outputs settled
   task automatic wr(input int k, input logic [3:0] d);
      on_enable_wdata_i = d[0];
      off_enable_wdata_i = d[0];
      vcode_wdata_i = d;
      on_enable_wr_i = (k == 0);
      off_enable_wr_i = (k == 1);
      vcode_wr_i = (k == 2);
      fuse_load_i = (k == 3);
      tick;
      {on_enable_wr_i, off_enable_wr_i, vcode_wr_i, fuse_load_i} = 4'h0;
      tick;
   endtask
   task automatic ps(input logic [1:0] s, input logic stay);
      power_state_i = s;
      stay_in_deep_off_i = stay;
      tick;
      tick;
   endtask
   function automatic logic [8:0] lvl(input logic [3:0] n);
      if (n == 4'h0) return 9'h0B4;
      if (n == 4'hF) return 9'h168;
      return 9'h0C8 + 9'h00A * (n - 4'h1);
   endfunction
   always @(posedge mclk_i) begin
      cyc++;
      if (cyc == 3000) begin
         bad_count++;
         finish_test;
      end
   end
   // ************************************************************
   // tests
   // ************************************************************
   initial begin
      tick;
      tick;
      reset_i = 1'b0;
      chk({on_q, off_q, chg_en, chg_hi, code_q}, 9'h000, "reset outputs");
      chk(lvl_q, 9'h0B4, "reset level");
      $display("test reset done");
      wr(0, 4'h1);
      chk({chg_en, chg_hi}, 9'h003, "run charging 60 uA");
      ps(2'b01, 1'b0);
      chk({chg_en, chg_hi}, 9'h002, "standby charging 10 uA");
      ps(2'b11, 1'b1);
      chk(chg_en, 9'h000, "other state stays off");
      ps(2'b00, 1'b0);
      wr(0, 4'h0);
      chk({on_q, chg_en}, 9'h000, "run charger off");
      $display("test run standby done");
      wr(0, 4'h1);
      wr(1, 4'h1);
      ps(2'b10, 1'b1);
      chk({off_q, chg_en, chg_hi}, 9'h006, "deep-off charging 10 uA");
      ps(2'b10, 1'b0);
      chk(chg_en, 9'h000, "deep-off without stay");
      wr(1, 4'h0);
      ps(2'b10, 1'b1);
      chk({off_q, chg_en}, 9'h000, "deep-off enable clear");
      ps(2'b00, 1'b0);
      $display("test deep-off done");
      for (int n = 0; n < 16; n++) begin
         wr(2, n[3:0]);
         chk({code_q, lvl_q}, {n[3:0], lvl(n[3:0])}, "code decode");
      end
      $display("test decode done");
      fuse_code = 4'hA;
      wr(3, 4'h3);
      chk({code_q, lvl_q}, {4'hA, 9'h122}, "fuse load");
      $display("test fuse done");
      wr(1, 4'h1);
      wr(2, 4'h2);
      fuse_code = 4'h6;
      chk({on_q, off_q}, 9'h003, "enables set before rise");
      uv_above_threshold_i = 1'b1;
      for (int i = 0; i < 10 && on_q !== 1'b0; i++) tick;
      tick;
      chk({on_q, off_q, chg_en}, 9'h000, "supply rise clears enables");
      chk({code_q, lvl_q}, {4'h6, 9'h0FA}, "supply rise restores fuse code");
      $display("test supply rise done");
      finish_test;
   end
endmodule
